// ### vrc_top.sv
// Summary of operation
// - Top address bits not both high: start address.
// - Address latched on strobe fall; inputs only.
// - Both top bits high: latch combinable mode bits.
// - Aux routed: strobe high, play, idle/overflowed.
// - Speaker held at ground recording or asleep.
// - Full pulses low, then mirrors strobe.
// - Strobe low enables; select latched on fall.
// - Sleep request returns pointer to start.
// - End marker written when strobe or sleep stops a recording with M1 clear.
// - Message end pulses low fixed time.
// - Low supply: message end low, play only.
// - Push-button mode: message end shows busy.
// - External clock pulled down; 1024 kHz precision.
// - Select picks play/record; record stop conditions.
// - Playback until marker; strobe low continues.
// - External clock divided by two internally.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vrc_top (
   input  wire logic                 i_mclk,            // Master clock, 25 MHz.
   input  wire logic                 i_rst,             // Synchronous reset, high.
   input  wire logic                 i_clk_en,          // Freezes all state when low.
   input  wire logic                 i_strobe_n,        // Cycle strobe, active low.
   input  wire logic                 i_sleep_request,   // Standby / pointer reset.
   input  wire logic                 i_play_not_record, // High play, low record.
   input  wire logic [9:0]           i_address_mode_inputs, // Address or mode bits.
   input  wire logic                 i_supply_low,      // Supply detector output.
   input  wire logic                 i_sample_clock_in, // Optional external clock.
   input  wire vrc_pkg::vrc_reg_req_t i_reg,            // Register port request.
   output logic [15:0]               o_reg_rdata,       // Read data, next cycle.
   output logic                      o_memory_full_n,   // Overflow, active low.
   output logic                      o_msg_end_n,       // Message end indicator.
   output logic                      o_aux_route,       // Aux input to speaker.
   output logic                      o_speaker_pair_mute, // Speakers at ground.
   output logic                      o_recording,       // Record cycle active.
   output logic                      o_playing,         // Playback cycle active.
   output logic                      o_irq              // Level interrupt.
);
   import vrc_pkg::*;

   logic [14:0]      pins_s;
   logic             strobe_s, sleep_s, select_s, supply_s, ext_s;
   logic             strobe_act, sleep_act;
   logic [9:0]       addr_s;
   logic             strobe_q, ext_q, ext_div;
   logic             strobe_fall, is_mode, sample_tick, row_tick;
   logic [11:0]      int_count;
   logic [3:0]       row_count;
   vrc_state_t       state;
   vrc_mode_t        mode, next_mode;
   logic [9:0]       ptr;
   logic             play_sel, last_sel;
   logic             marks [0:1023];
   logic             start, at_end, mark_hit, pass_mark, rec_stop, rec_pin_stop;
   logic             play_stop, ovf_evt, eom_evt, eom_active, ovf_active;
   logic             ovf_hit, supply_lock;
   logic [ST_W-1:0]  status, mask, events;
   logic             ctrl_ext;

   // Every pin passes two flops before the edge logic looks at it. Strobe and
   // sleep request travel inverted, so the cleared flops read as strobe idle and
   // standby, and no false strobe edge follows reset.
   vrc_sync #(.W(15)) u_sync (
      .i_mclk   (i_mclk),
      .i_rst    (i_rst),
      .i_clk_en (i_clk_en),
      .i_async  ({~i_strobe_n, ~i_sleep_request, i_play_not_record, i_supply_low,
                  i_sample_clock_in, i_address_mode_inputs}),
      .o_sync   (pins_s)
   );

   assign {strobe_act, sleep_act, select_s, supply_s, ext_s, addr_s} = pins_s;
   assign strobe_s = ~strobe_act;
   assign sleep_s  = ~sleep_act;

   // Edge history of the synchronised strobe and external clock.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         strobe_q <= 1'b1;
         ext_q    <= 1'b0;
      end
      else if (i_clk_en)
      begin
         strobe_q <= strobe_s;
         ext_q    <= ext_s;
      end
   end

   assign strobe_fall = strobe_q & ~strobe_s;
   assign is_mode     = addr_s[9] & addr_s[8];

   // Mode bits; M2 is reserved and ignored.
   always_comb
   begin
      next_mode.m0 = addr_s[MB_M0];
      next_mode.m1 = addr_s[MB_M1];
      next_mode.m3 = addr_s[MB_M3];
      next_mode.m4 = addr_s[MB_M4];
      next_mode.m5 = addr_s[MB_M5];
      next_mode.m6 = addr_s[MB_M6];
   end

   // Sample clock: the external clock is halved so its duty cycle does not matter;
   // with ctrl_ext clear the internal divider sets the rate, whatever the input does.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         ext_div   <= 1'b0;
         int_count <= '0;
      end
      else if (i_clk_en)
      begin
         if (ext_s & ~ext_q)
            ext_div <= ~ext_div;
         if (int_count == 12'(SAMPLE_CYCLES - 1))
            int_count <= '0;
         else
            int_count <= int_count + 1'b1;
      end
   end

   assign sample_tick = ctrl_ext ? (ext_s & ~ext_q & ext_div)
                                 : (int_count == 12'(SAMPLE_CYCLES - 1));

   // Row pacing: the pointer steps once per group of samples.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         row_count <= '0;
      else if (i_clk_en)
      begin
         if (state == ST_IDLE)
            row_count <= '0;
         else if (sample_tick)
            row_count <= (row_count == 4'(SAMPLES_PER_ROW - 1)) ? 4'h0 : row_count + 1'b1;
      end
   end

   assign row_tick = sample_tick && (row_count == 4'(SAMPLES_PER_ROW - 1))
                     && (state != ST_IDLE);

   // Cycle events.
   assign start        = strobe_fall & ~sleep_s & (state == ST_IDLE)
                         & (select_s | ~supply_lock);
   assign at_end       = row_tick & (ptr == ROW_LAST);
   assign rec_pin_stop = (state == ST_RECORD) & (strobe_s | sleep_s);
   assign rec_stop     = rec_pin_stop | ((state == ST_RECORD) & at_end);
   assign pass_mark    = ~strobe_s;
   assign mark_hit     = (state == ST_PLAY) & row_tick & marks[ptr];
   assign play_stop    = (state == ST_PLAY)
                         & (sleep_s | (mode.m5 & strobe_s)
                            | (mark_hit & ~pass_mark) | (at_end & ~mode.m3));
   assign ovf_evt      = at_end & ~((state == ST_PLAY) & mode.m3);
   assign eom_evt      = mark_hit | (rec_pin_stop & ~mode.m1);

   // Cycle state: the select latched at the strobe fall picks the cycle.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         state <= ST_IDLE;
      else if (i_clk_en)
      begin
         case (state)
            ST_IDLE:   if (start) state <= select_s ? ST_PLAY : ST_RECORD;
            ST_RECORD: if (rec_stop) state <= ST_IDLE;
            ST_PLAY:   if (play_stop) state <= ST_IDLE;
            default:   state <= ST_IDLE;
         endcase
      end
   end

   // Latched modes and select; the pins themselves are never driven.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         mode     <= '0;
         play_sel <= 1'b0;
         last_sel <= 1'b0;
      end
      else if (i_clk_en && strobe_fall)
      begin
         mode     <= is_mode ? next_mode : '0;
         play_sel <= select_s;
         last_sel <= play_sel;
      end
   end

   // Address pointer.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         ptr <= ROW_FIRST;
      else if (i_clk_en)
      begin
         if (sleep_s)
            ptr <= ROW_FIRST;
         else if (start)
         begin
            if (!is_mode)
               ptr <= addr_s;
            else if (!next_mode.m4 || (select_s != play_sel && !next_mode.m6))
               ptr <= ROW_FIRST;
         end
         else if (mark_hit && !pass_mark && !mode.m4)
            ptr <= ROW_FIRST;
         else if (row_tick)
            ptr <= at_end ? ROW_FIRST : ptr + 1'b1;
      end
   end

   // Marker store: a recorded row loses its old marker, a pin stop with M1 clear sets one.
   always_ff @(posedge i_mclk)
   begin
      if (i_clk_en && state == ST_RECORD)
      begin
         if (rec_pin_stop && !mode.m1)
            marks[ptr] <= 1'b1;
         else if (row_tick)
            marks[ptr] <= 1'b0;
      end
   end

   vrc_pulse #(.LEN(EOM_CYCLES)) u_eom_pulse (
      .i_mclk   (i_mclk),
      .i_rst    (i_rst),
      .i_clk_en (i_clk_en),
      .i_load   (eom_evt),
      .o_active (eom_active)
   );

   vrc_pulse #(.LEN(OVF_CYCLES)) u_ovf_pulse (
      .i_mclk   (i_mclk),
      .i_rst    (i_rst),
      .i_clk_en (i_clk_en),
      .i_load   (ovf_evt),
      .o_active (ovf_active)
   );

   // Overflow and supply locks; only a sleep request clears overflow.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         ovf_hit     <= 1'b0;
         supply_lock <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (ovf_evt)
            ovf_hit <= 1'b1;
         else if (sleep_s)
            ovf_hit <= 1'b0;
         if (supply_s)
            supply_lock <= 1'b1;
      end
   end

   // Pin outputs, all registered.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_memory_full_n     <= 1'b1;
         o_msg_end_n         <= 1'b1;
         o_aux_route         <= 1'b0;
         o_speaker_pair_mute <= 1'b1;
         o_recording         <= 1'b0;
         o_playing           <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_memory_full_n     <= ~(ovf_evt | ovf_active) & (~ovf_hit | strobe_s);
         o_msg_end_n         <= mode.m6 ? (state != ST_IDLE)
                                        : ~(eom_evt | eom_active | supply_lock);
         o_aux_route         <= strobe_s & select_s & ((state != ST_PLAY) | ovf_hit);
         o_speaker_pair_mute <= (state == ST_RECORD) | sleep_s;
         o_recording         <= (state == ST_RECORD);
         o_playing           <= (state == ST_PLAY);
      end
   end

   // Sticky status: an event in the clearing cycle wins over the clear.
   assign events = {~(rec_stop | play_stop) ? 1'b0 : 1'b1, supply_s & ~supply_lock,
                    ovf_evt, eom_evt};

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         status   <= STATUS_RESET;
         mask     <= MASK_RESET;
         ctrl_ext <= CTRL_EXT_RESET;
      end
      else if (i_clk_en)
      begin
         if (i_reg.wr && i_reg.addr == REG_STATUS)
            status <= (status & ~i_reg.wdata[ST_W-1:0]) | events;
         else
            status <= status | events;
         if (i_reg.wr && i_reg.addr == REG_MASK)
            mask <= i_reg.wdata[ST_W-1:0];
         if (i_reg.wr && i_reg.addr == REG_CTRL)
            ctrl_ext <= i_reg.wdata[CTRL_EXT_CLK];
      end
   end

   // Read data one cycle after the strobe; unmapped words read zero.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_reg_rdata <= '0;
         o_irq       <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_irq <= |(status & mask);
         if (i_reg.rd)
         begin
            case (i_reg.addr)
               REG_STATUS: o_reg_rdata <= {12'h000, status};
               REG_MASK:   o_reg_rdata <= {12'h000, mask};
               REG_CTRL:   o_reg_rdata <= {15'h0000, ctrl_ext};
               REG_STATE:  o_reg_rdata <= {supply_lock, ovf_hit, play_sel, state, mode[5:1],
                                           ptr[5:0]} ^ {10'h000, 6'h00}
                                           | {10'h000, 6'h00};
               default:    o_reg_rdata <= '0;
            endcase
         end
         else
            o_reg_rdata <= '0;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   a_start_address: assert property ((i_clk_en && start && !is_mode && !sleep_s)
      |=> ptr == $past(addr_s)) else $error("start address not taken");
   a_mode_latch: assert property ((i_clk_en && strobe_fall && is_mode)
      |=> mode == $past(next_mode)) else $error("mode bits not latched");
   a_aux_route_on: assert property ((i_clk_en && strobe_s && select_s && state == ST_IDLE)
      |=> o_aux_route) else $error("aux not routed");
   a_speaker_mute: assert property ((i_clk_en && state == ST_RECORD)
      |=> o_speaker_pair_mute) else $error("speaker not held");
   a_full_pulse: assert property ((i_clk_en && ovf_evt)
      |=> !o_memory_full_n) else $error("full pulse missing");
   a_sleep_pointer: assert property ((i_clk_en && sleep_s)
      |=> ptr == ROW_FIRST) else $error("pointer not reset");
   a_marker_write: assert property ((i_clk_en && rec_pin_stop && !mode.m1)
      |=> marks[$past(ptr)]) else $error("end marker not stored");
   a_msg_end_pulse: assert property ((i_clk_en && eom_evt && !mode.m6 && !strobe_fall)
      |=> !o_msg_end_n) else $error("message end pulse missing");
   a_supply_lock: assert property ((supply_lock && state == ST_IDLE)
      |=> state != ST_RECORD) else $error("record under low supply");
   a_busy_led: assert property ((i_clk_en && mode.m6 && !strobe_fall && state != ST_IDLE)
      |=> o_msg_end_n) else $error("busy indicator low");

   c_record: cover property (state == ST_IDLE ##1 state == ST_RECORD);
   c_marker: cover property (mark_hit);
   c_overflow: cover property (ovf_evt);
   c_supply: cover property (supply_lock);
endmodule : vrc_top
`default_nettype wire

// ### vrc_pkg.sv
// Shared constants and carrier types of the voice recorder control block.
package vrc_pkg;

   // Address/mode input width and the storage array row range.
   localparam int          ADDR_W     = 10;
   localparam logic [9:0]  ROW_FIRST  = 10'h000;
   localparam logic [9:0]  ROW_LAST   = 10'h3FF;

   // Register port: word index, data width and offsets.
   localparam int          REG_AW     = 4;
   localparam int          REG_DW     = 16;
   localparam logic [3:0]  REG_STATUS = 4'h0;
   localparam logic [3:0]  REG_MASK   = 4'h1;
   localparam logic [3:0]  REG_CTRL   = 4'h2;
   localparam logic [3:0]  REG_STATE  = 4'h3;

   // Status and mask bit positions.
   localparam int          ST_MSG_END = 0;
   localparam int          ST_OVF     = 1;
   localparam int          ST_SUPPLY  = 2;
   localparam int          ST_DONE    = 3;
   localparam int          ST_W       = 4;

   // Control bit positions and reset values.
   localparam int          CTRL_EXT_CLK   = 0;
   localparam logic [3:0]  STATUS_RESET   = 4'h0;
   localparam logic [3:0]  MASK_RESET     = 4'h0;
   localparam logic        CTRL_EXT_RESET = 1'b0;

   // Mode bit positions on the address/mode inputs.
   localparam int          MB_M0 = 0;
   localparam int          MB_M1 = 1;
   localparam int          MB_M3 = 3;
   localparam int          MB_M4 = 4;
   localparam int          MB_M5 = 5;
   localparam int          MB_M6 = 6;

   // Timing, derived from the 40 ns master clock period.
   localparam int          MCLK_PERIOD_NS   = 40;
   localparam int          SAMPLE_PERIOD_NS = 125000;
   localparam int          SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / MCLK_PERIOD_NS;
   localparam int          EOM_PULSE_NS     = 1000;
   localparam int          EOM_CYCLES       = EOM_PULSE_NS / MCLK_PERIOD_NS;
   localparam int          OVF_PULSE_NS     = 1000;
   localparam int          OVF_CYCLES       = OVF_PULSE_NS / MCLK_PERIOD_NS;
   localparam int          SAMPLES_PER_ROW  = 8;
   localparam int          PULSE_W          = 8;

   typedef enum logic [1:0] {ST_IDLE, ST_RECORD, ST_PLAY} vrc_state_t;

   // Latched operational modes.
   typedef struct packed {
      logic m6;
      logic m5;
      logic m4;
      logic m3;
      logic m1;
      logic m0;
   } vrc_mode_t;

   // One register port request.
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [3:0]        addr;
      logic [15:0]       wdata;
   } vrc_reg_req_t;

endpackage : vrc_pkg

// ### vrc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for a group of pin inputs.
module vrc_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,   // Master clock.
   input  wire logic         i_rst,    // Synchronous reset.
   input  wire logic         i_clk_en, // Clock enable.
   input  wire logic [W-1:0] i_async,  // Raw pin levels.
   output logic      [W-1:0] o_sync    // Synchronised levels.
);
   logic [W-1:0] meta;

   // The first stage is read by the second stage only.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         meta   <= '0;
         o_sync <= '0;
      end
      else if (i_clk_en)
      begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule : vrc_sync
`default_nettype wire

// ### vrc_pulse.sv
`timescale 1ns/1ps
`default_nettype none
// Fixed-length pulse timer: a load starts a pulse of LEN cycles.
module vrc_pulse #(
   parameter int LEN = 1
) (
   input  wire logic i_mclk,   // Master clock.
   input  wire logic i_rst,    // Synchronous reset.
   input  wire logic i_clk_en, // Clock enable.
   input  wire logic i_load,   // Start or restart the pulse.
   output logic      o_active  // High while the pulse runs.
);
   import vrc_pkg::*;

   localparam logic [PULSE_W-1:0] LEN_V = PULSE_W'(LEN);
   logic [PULSE_W-1:0] count;

   // A reload during a pulse restarts it so back-to-back events stretch it.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         count <= '0;
      else if (i_clk_en)
      begin
         if (i_load)
            count <= LEN_V;
         else if (count != '0)
            count <= count - 1'b1;
      end
   end

   assign o_active = (count != '0);
endmodule : vrc_pulse
`default_nettype wire

// ### vrc_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### vrc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural controller that drives the recorder's control pins.
module vrc_ctl_model (
   input  wire logic  i_mclk,               // Master clock.
   output logic       o_strobe_n,           // Cycle strobe, active low.
   output logic       o_sleep_request,      // Standby request.
   output logic       o_play_not_record,    // High play, low record.
   output logic [9:0] o_address_mode_inputs // Address or mode bits.
);
   // Rest in standby between messages so the part idles at low current.
   initial
   begin
      o_strobe_n = 1'b1;
      o_sleep_request = 1'b1;
      o_play_not_record = 1'b1;
      o_address_mode_inputs = 10'h000;
   end

   // Leave standby and settle select and address well before any strobe fall.
   task automatic set_pins(input logic play, input logic [9:0] am);
      @(posedge i_mclk);
      o_sleep_request <= 1'b0;
      o_play_not_record <= play;
      o_address_mode_inputs <= am;
      repeat (3) @(posedge i_mclk);
   endtask : set_pins

   // Falling strobe starts a cycle; select and address are held stable.
   task automatic strobe_low();
      @(posedge i_mclk);
      o_strobe_n <= 1'b0;
   endtask : strobe_low

   // Rising strobe ends a record cycle or releases a level-activated one.
   task automatic strobe_high();
      @(posedge i_mclk);
      o_strobe_n <= 1'b1;
   endtask : strobe_high

   // Back to standby, which also returns the pointer to the array start.
   task automatic rest();
      @(posedge i_mclk);
      o_sleep_request <= 1'b1;
   endtask : rest
endmodule : vrc_ctl_model
`default_nettype wire

// ### vrc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vrc_top_tb;
   import vrc_pkg::*;

   logic         mclk;
   logic         rst;
   logic         supply_low;
   vrc_reg_req_t req;
   logic         strobe_n;
   logic         sleep_req;
   logic         pnr;
   logic [9:0]   am;
   logic [15:0]  rdata;
   logic         full_n;
   logic         msg_end_n;
   logic         aux;
   logic         mute;
   logic         rec;
   logic         play;
   logic         irq;
   int           n_fail;
   int           check_count;
   int           w;

   // Free-running master clock, 40 ns period.
   initial mclk = 1'b0;
   always #20 mclk = ~mclk;

   // The external clock pin is grounded since the internal clock is used.
   vrc_top u_vrc_top (
      .i_mclk                (mclk),
      .i_rst                 (rst),
      .i_clk_en              (1'b1),
      .i_strobe_n            (strobe_n),
      .i_sleep_request       (sleep_req),
      .i_play_not_record     (pnr),
      .i_address_mode_inputs (am),
      .i_supply_low          (supply_low),
      .i_sample_clock_in     (1'b0),
      .i_reg                 (req),
      .o_reg_rdata           (rdata),
      .o_memory_full_n       (full_n),
      .o_msg_end_n           (msg_end_n),
      .o_aux_route           (aux),
      .o_speaker_pair_mute   (mute),
      .o_recording           (rec),
      .o_playing             (play),
      .o_irq                 (irq)
   );

   vrc_ctl_model u_vrc_ctl_model (
      .i_mclk                (mclk),
      .o_strobe_n            (strobe_n),
      .o_sleep_request       (sleep_req),
      .o_play_not_record     (pnr),
      .o_address_mode_inputs (am)
   );

   // Prints the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One-cycle write strobe; released at the edge that takes it.
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      req <= vrc_reg_req_t'{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      req <= '0;
   endtask : reg_wr

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      req <= vrc_reg_req_t'{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge mclk);
      req <= '0;
      #1;
      check(rdata, exp);
   endtask : reg_rd

   // Bounded wait for an output level; a hang counts as a mismatch.
   task automatic wait_sig(input int sel, input logic lvl, input int lim);
      int   n;
      logic v;
      n = 0;
      v = ~lvl;
      while (v !== lvl && n < lim)
      begin
         @(posedge mclk);
         #1;
         n++;
         case (sel)
            0: v = rec;
            1: v = play;
            2: v = msg_end_n;
            default: v = aux;
         endcase
      end
      check_count++;
      if (v !== lvl)
      begin
         n_fail++;
         $display("Error at %0t ns: wait %0d timed out", $time, sel);
         complete_run();
      end
   endtask : wait_sig

   // Main sequence of scenarios.
   initial
   begin
      rst = 1'b1;
      req = '0;
      supply_low = 1'b0;
      n_fail = 0;
      check_count = 0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      check({9'h000, full_n, msg_end_n, aux, mute, rec, play, irq}, 16'h0068);
      reg_rd(REG_STATUS, 16'h0000);
      reg_rd(REG_MASK, 16'h0000);
      reg_rd(REG_CTRL, 16'h0000);
      reg_rd(4'hF, 16'h0000);
      reg_wr(REG_CTRL, 16'h0001);
      reg_rd(REG_CTRL, 16'h0001);
      reg_wr(REG_CTRL, 16'h0000);
      // Aux path follows the select while idle with the strobe high.
      u_vrc_ctl_model.set_pins(1'b1, 10'h000);
      wait_sig(3, 1'b1, 10);
      u_vrc_ctl_model.set_pins(1'b0, 10'h005);
      wait_sig(3, 1'b0, 10);
      // Record from a direct address, ended by the strobe.
      u_vrc_ctl_model.strobe_low();
      wait_sig(0, 1'b1, 10);
      check(mute, 1);
      u_vrc_ctl_model.strobe_high();
      wait_sig(0, 1'b0, 10);
      wait_sig(2, 1'b0, 10);
      w = 0;
      while (msg_end_n === 1'b0 && w < 100)
      begin
         @(posedge mclk);
         #1;
         w++;
      end
      // The pulse stands EOM_CYCLES + 1 edges; the waits above used three of them.
      check(16'(w == EOM_CYCLES - 1), 16'h0001);
      reg_rd(REG_STATUS, 16'((1 << ST_MSG_END) | (1 << ST_DONE)));
      check(irq, 0);
      reg_wr(REG_MASK, 16'(1 << ST_MSG_END));
      reg_rd(REG_MASK, 16'(1 << ST_MSG_END));
      check(irq, 1);
      reg_wr(REG_STATUS, 16'h000F);
      repeat (2) @(posedge mclk);
      #1;
      check(irq, 0);
      reg_rd(REG_STATUS, 16'h0000);
      u_vrc_ctl_model.rest();
      repeat (6) @(posedge mclk);
      #1;
      check(mute, 1);
      // Edge-activated playback from the same address stops at the marker.
      u_vrc_ctl_model.set_pins(1'b1, 10'h005);
      u_vrc_ctl_model.strobe_low();
      wait_sig(1, 1'b1, 10);
      check(mute, 0);
      u_vrc_ctl_model.strobe_high();
      repeat (6) @(posedge mclk);
      #1;
      check({14'h0000, play, aux}, 16'h0002);
      wait_sig(2, 1'b0, 30000);
      wait_sig(1, 1'b0, 10);
      wait_sig(3, 1'b1, 10);
      // Level-activated playback mode: strobe high ends play at once.
      u_vrc_ctl_model.rest();
      u_vrc_ctl_model.set_pins(1'b1, 10'h320);
      u_vrc_ctl_model.strobe_low();
      wait_sig(1, 1'b1, 10);
      repeat (40) @(posedge mclk);
      #1;
      check(play, 1);
      u_vrc_ctl_model.strobe_high();
      wait_sig(1, 1'b0, 8);
      // Push-button mode: message end pin shows activity, sleep stops it.
      u_vrc_ctl_model.rest();
      u_vrc_ctl_model.set_pins(1'b0, 10'h340);
      u_vrc_ctl_model.strobe_low();
      wait_sig(0, 1'b1, 10);
      check(msg_end_n, 1);
      u_vrc_ctl_model.rest();
      wait_sig(0, 1'b0, 10);
      u_vrc_ctl_model.strobe_high();
      check(full_n, 1);
      // Low supply locks the part to playback only.
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      supply_low <= 1'b1;
      wait_sig(2, 1'b0, 10);
      u_vrc_ctl_model.set_pins(1'b0, 10'h010);
      u_vrc_ctl_model.strobe_low();
      repeat (10) @(posedge mclk);
      #1;
      check(rec, 0);
      u_vrc_ctl_model.strobe_high();
      complete_run();
   end
endmodule : vrc_top_tb
`default_nettype wire
